// file: rtl/smsp_pkg.sv
// Purpose: Shared constants, types and helpers of the SPI port.
// Assumes: Byte-wide special function register access.
// Notes:   Offsets, field positions and reset values live here only.
package smsp_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int         ADDR_W      = 8;       // Register address width.
  localparam logic [7:0] ADDR_STATUS = 8'h84;   // Status register.
  localparam logic [7:0] ADDR_CTRL   = 8'h85;   // Control register.
  localparam logic [7:0] ADDR_DATA   = 8'h86;   // Data register.

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTL_SEL_IGN = 7;   // Select pin ignore.
  localparam int CTL_EN      = 6;   // Port enable.
  localparam int CTL_ORDER   = 5;   // Bit order, 1 is LSB first.
  localparam int CTL_MASTER_SELECT    = 4;   // Master select.
  localparam int CTL_CLOCK_POLARITY    = 3;   // Clock polarity.
  localparam int CTL_CLOCK_PHASE    = 2;   // Clock phase.
  localparam int ST_DONE     = 7;   // Transfer done flag.
  localparam int ST_HOLD     = 6;   // Holding register full flag, set while a byte waits.
  localparam int ST_RATE2    = 0;   // Rate select bit 2.

  // ----------------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_RST  = 8'h00;  // Control after reset.
  localparam logic [7:0] BYTE_RST  = 8'h00;  // Data registers after reset.
  localparam logic [3:0] LAST_HALF = 4'hF;   // Last of 16 clock half periods.
  localparam logic [2:0] LAST_BIT  = 3'h7;   // Last of 8 sampled bits.
  localparam logic [5:0] ONE_CYC   = 6'h01;  // One clock cycle.

  // Master engine states.
  typedef enum logic {ST_IDLE, ST_RUN} smsp_state_t;

  // Half of the system clock divisor chosen by the three rate bits.
  function automatic logic [5:0] smsp_half(input logic [2:0] sel);
    logic [5:0] h;
    h = 6'h02;
    unique case (sel)
      3'h0: h = 6'h02;   // Divide by 4.
      3'h1: h = 6'h03;   // Divide by 6.
      3'h2: h = 6'h04;   // Divide by 8.
      3'h3: h = 6'h06;   // Divide by 12.
      3'h4: h = 6'h08;   // Divide by 16.
      3'h5: h = 6'h0C;   // Divide by 24.
      3'h6: h = 6'h18;   // Divide by 48.
      3'h7: h = 6'h30;   // Divide by 96.
    endcase
    return h;
  endfunction : smsp_half

  // The bit of a byte that goes out next for the chosen bit order.
  function automatic logic smsp_first(input logic lsb, input logic [7:0] b);
    return lsb ? b[0] : b[7];
  endfunction : smsp_first

endpackage : smsp_pkg

// file: rtl/smsp_rate.sv
// Purpose: Serial clock half period tick generator for master mode.
// Assumes: Run drops between transfers so each byte starts aligned.
// Notes:   One tick per half period of the serial clock.
`timescale 1ns/1ns
`default_nettype none
module smsp_rate
(
  input  wire logic       clk,    // System clock.
  input  wire logic       rst,    // Asynchronous reset, active high.
  input  wire logic       run,    // Generator runs while high.
  input  wire logic [2:0] sel,    // Rate select.
  output logic            tick    // One cycle per half period.
);
  import smsp_pkg::*;

  logic [5:0] cnt_reg;   // Cycles into the current half period.

  // A tick ends each half period of the chosen divisor.
  always_comb
  begin
    tick = run && (cnt_reg == smsp_half(sel) - ONE_CYC);
  end

  // The counter restarts on every tick and while stopped.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_reg <= 6'h00;
    else if (!run || tick)
      cnt_reg <= 6'h00;
    else
      cnt_reg <= cnt_reg + ONE_CYC;
  end

endmodule : smsp_rate
`default_nettype wire

// file: rtl/smsp_port.sv
// Purpose: Byte-wide SPI master and slave port with three registers.
// Assumes: Pins come from outside the clock domain and are synchronised.
// Notes:   Output enables low mean the pin is left to general I/O.
`timescale 1ns/1ns
`default_nettype none
module smsp_port
(
  input  wire logic                        CORE_CLK,   // System clock.
  input  wire logic                        SYS_RST,    // Async reset.
  input  wire logic [smsp_pkg::ADDR_W-1:0] SFR_ADDR,   // Register address.
  input  wire logic                        SFR_WR,     // Write strobe.
  input  wire logic                        SFR_RD,     // Read strobe.
  input  wire logic [7:0]                  SFR_WDATA,  // Write data.
  output logic [7:0]                       SFR_RDATA,  // Read data.
  input  wire logic                        SPI_IE,     // Interrupt enable.
  output logic                             SPI_IRQ,    // Interrupt request.
  input  wire logic                        SS_N_IN,    // Slave select pin.
  input  wire logic                        SCLK_IN,    // Clock pin level.
  output logic                             SCLK_OUT,   // Clock pin drive.
  output logic                             SCLK_OE,    // Clock pin enable.
  input  wire logic                        MOSI_IN,    // MOSI pin level.
  output logic                             MOSI_OUT,   // MOSI pin drive.
  output logic                             MOSI_OE,    // MOSI pin enable.
  input  wire logic                        MISO_IN,    // MISO pin level.
  output logic                             MISO_OUT,   // MISO pin drive.
  output logic                             MISO_OE     // MISO pin enable.
);
  import smsp_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0]  ctrl_reg;            // Control register.
  logic        rate2_reg;           // Rate select bit 2.
  logic        flag_reg;            // Transfer done flag.
  logic        holding_empty_flag_reg;            // Holding register full flag.
  logic [7:0]  thr_reg;             // Transmit holding register.
  logic [7:0]  rx_reg;              // Received byte.
  logic [7:0]  sh_reg, sh_next;     // Shift register and next value.
  logic        out_reg;             // Bit driven on the data pin.
  logic        sclk_reg;            // Driven serial clock level.
  logic [3:0]  half_reg;            // Master half periods done.
  logic [2:0]  bits_reg;            // Bits sampled this byte.
  logic        msamp_reg;           // Master sample strobe, one cycle late.
  logic        mlast_reg;           // Master last half period, one late.
  logic [7:0]  rdata_reg;           // Registered read data.
  smsp_state_t state_reg;           // Master engine state.
  logic ss_s1, ss_s2, sck_s1, sck_s2, sck_s3;  // Pin synchronisers.
  logic mo_s1, mo_s2, mi_s1, mi_s2;            // Data synchronisers.

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic en, ign, lsb, master_select, clock_polarity, clock_phase, busy, tick, is_master, ss_low;
  logic mode_chg, slave_sel, wr_ctl, wr_st, wr_dat, load, in_bit;
  logic lead, trail, samp, chg, done_evt, s_rise, s_fall;
  logic [2:0] sel;                   // Full rate select.

  always_comb
  begin
    en        = ctrl_reg[CTL_EN];
    ign       = ctrl_reg[CTL_SEL_IGN];
    lsb       = ctrl_reg[CTL_ORDER];
    master_select      = ctrl_reg[CTL_MASTER_SELECT];
    clock_polarity      = ctrl_reg[CTL_CLOCK_POLARITY];
    clock_phase      = ctrl_reg[CTL_CLOCK_PHASE];
    sel       = {rate2_reg, ctrl_reg[1:0]};
    busy      = (state_reg == ST_RUN);
    ss_low    = !ss_s2;
    // Role comes from the master bit; the pin can only demote it.
    is_master = en && master_select;
    mode_chg  = is_master && !ign && ss_low;
    slave_sel = en && !master_select && (ign || ss_low);
    wr_ctl    = SFR_WR && (SFR_ADDR == ADDR_CTRL);
    wr_st     = SFR_WR && (SFR_ADDR == ADDR_STATUS);
    wr_dat    = SFR_WR && (SFR_ADDR == ADDR_DATA);
    // Never load in the cycle of a data write so no byte is torn.
    load      = holding_empty_flag_reg && !wr_dat && ((is_master && !busy && !mode_chg)
                || (en && !master_select && bits_reg == 3'h0 && !s_rise && !s_fall));
    s_rise    = sck_s2 && !sck_s3;
    s_fall    = !sck_s2 && sck_s3;
    // Leading edge leaves the idle level, trailing returns to it.
    lead      = (busy && tick && !half_reg[0])
                || (slave_sel && (clock_polarity ? s_fall : s_rise));
    trail     = (busy && tick && half_reg[0])
                || (slave_sel && (clock_polarity ? s_rise : s_fall));
    // A master samples one cycle after its edge so MISO clears the sync.
    samp      = (busy && msamp_reg)
                || (!busy && slave_sel && (clock_phase ? trail : lead));
    chg       = clock_phase ? lead : trail;
    in_bit    = is_master ? mi_s2 : mo_s2;
    done_evt  = busy ? mlast_reg
                     : (slave_sel && samp && bits_reg == LAST_BIT);
  end

  // Shift in the sampled bit at the far end from the outgoing bit.
  always_comb
  begin
    sh_next = sh_reg;
    if (samp)
      sh_next = lsb ? {in_bit, sh_reg[7:1]} : {sh_reg[6:0], in_bit};
  end

  // ----------------------------------------------------------------------
  // Synchronisers and rate generator
  // ----------------------------------------------------------------------
  // Each pin passes two flops; the clock gets a third for edges.
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      {ss_s1, ss_s2} <= 2'h3;
      {sck_s1, sck_s2, sck_s3} <= 3'h0;
      {mo_s1, mo_s2, mi_s1, mi_s2} <= 4'h0;
    end
    else
    begin
      ss_s1 <= SS_N_IN;
      ss_s2 <= ss_s1;
      sck_s1 <= SCLK_IN;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      mo_s1 <= MOSI_IN;
      mo_s2 <= mo_s1;
      mi_s1 <= MISO_IN;
      mi_s2 <= mi_s1;
    end
  end

  // The divider only runs during a master transfer.
  smsp_rate u_rate
  (
    .clk  (CORE_CLK),
    .rst  (SYS_RST),
    .run  (busy),
    .sel  (sel),
    .tick (tick)
  );

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Control register; a mode change demotes the master after any write.
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      ctrl_reg <= CTRL_RST;
    else
    begin
      if (wr_ctl)
        ctrl_reg <= SFR_WDATA;
      if (mode_chg)
        ctrl_reg[CTL_MASTER_SELECT] <= 1'b0;
    end
  end

  // Status bits: done flag sets over a clear, holding flag tracks the TX_HOLDING_REG.
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rate2_reg <= 1'b0;
      flag_reg  <= 1'b0;
      holding_empty_flag_reg  <= 1'b0;
    end
    else
    begin
      if (wr_st)
        rate2_reg <= SFR_WDATA[ST_RATE2];
      flag_reg <= done_evt || mode_chg
                  || (flag_reg && !(wr_st && SFR_WDATA[ST_DONE]));
      if (wr_dat)
        holding_empty_flag_reg <= 1'b1;
      else if (load)
        holding_empty_flag_reg <= 1'b0;
    end
  end

  // Data path: holding register, shifter, pin bit and received byte.
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      thr_reg <= BYTE_RST;
      sh_reg  <= BYTE_RST;
      rx_reg  <= BYTE_RST;
      out_reg <= 1'b0;
    end
    else
    begin
      if (wr_dat)
        thr_reg <= SFR_WDATA;
      sh_reg <= load ? thr_reg : sh_next;
      if (done_evt)
        rx_reg <= sh_next;
      // The first bit stands from the load, the rest follow change edges.
      if (load)
        out_reg <= smsp_first(lsb, thr_reg);
      else if (chg)
        out_reg <= smsp_first(lsb, sh_reg);
    end
  end

  // Master engine: a pending byte starts it, sixteen half periods end it.
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      state_reg <= ST_IDLE;
    else
      unique case (state_reg)
        ST_IDLE: if (load && is_master) state_reg <= ST_RUN;
        ST_RUN:  if (done_evt || mode_chg || !is_master)
                   state_reg <= ST_IDLE;
      endcase
  end

  // Counters and the driven clock, which rests at the polarity level.
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      half_reg <= 4'h0;
      bits_reg <= 3'h0;
      sclk_reg <= 1'b0;
      msamp_reg <= 1'b0;
      mlast_reg <= 1'b0;
    end
    else
    begin
      half_reg <= load ? 4'h0 : (tick ? half_reg + 4'h1 : half_reg);
      // MISO reaches the core two cycles late, so the sample waits one.
      msamp_reg <= busy && tick && (half_reg[0] == clock_phase);
      mlast_reg <= busy && tick && (half_reg == LAST_HALF);
      if (load || done_evt || (!ign && !ss_low && !master_select))
        bits_reg <= 3'h0;
      else if (samp)
        bits_reg <= bits_reg + 3'h1;
      if (!busy)
        sclk_reg <= clock_polarity;
      else if (tick)
        sclk_reg <= !sclk_reg;
    end
  end

  // Read data is captured on the read strobe.
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      rdata_reg <= BYTE_RST;
    else if (SFR_RD)
      unique case (SFR_ADDR)
        ADDR_CTRL:   rdata_reg <= ctrl_reg;
        ADDR_STATUS: rdata_reg <= {flag_reg, holding_empty_flag_reg, 5'h00, rate2_reg};
        ADDR_DATA:   rdata_reg <= rx_reg;
        default:     rdata_reg <= BYTE_RST;
      endcase
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_comb
  begin
    SFR_RDATA = rdata_reg;
    SPI_IRQ   = flag_reg && SPI_IE;
    SCLK_OUT  = sclk_reg;
    MOSI_OUT  = out_reg;
    MISO_OUT  = out_reg;
    // Disabled port drives nothing; idle master floats its outputs unless the ignore bit is set.
    SCLK_OE   = is_master && (busy || ign);
    MOSI_OE   = is_master && (busy || ign);
    MISO_OE   = slave_sel;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [5:0] gap_reg;   // Cycles since start or last tick.

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      gap_reg <= 6'h00;
    else
      gap_reg <= (!busy || tick) ? 6'h00 : gap_reg + ONE_CYC;
  end

  property p_off;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    !en |-> !SCLK_OE && !MOSI_OE && !MISO_OE;
  endproperty
  a_off: assert property (p_off) else $error("pin driven while off");

  property p_rate;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    tick |-> gap_reg == smsp_half(sel) - ONE_CYC;
  endproperty
  a_rate: assert property (p_rate) else $error("bad half period");

  property p_done;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    done_evt |=> flag_reg && (!SPI_IE || SPI_IRQ);
  endproperty
  a_done: assert property (p_done) else $error("flag not set");

  property p_hold_flag;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    flag_reg && !(wr_st && SFR_WDATA[ST_DONE]) |=> flag_reg;
  endproperty
  a_hold_flag: assert property (p_hold_flag) else $error("flag lost");

  property p_holding_empty_flag;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    wr_dat |=> holding_empty_flag_reg && thr_reg == $past(SFR_WDATA);
  endproperty
  a_holding_empty_flag: assert property (p_holding_empty_flag) else $error("holding not set");

  property p_mode;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    mode_chg |=> !master_select && flag_reg && !busy;
  endproperty
  a_mode: assert property (p_mode) else $error("no mode change");

  property p_idle_float;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    is_master && !busy && !ign |-> !MOSI_OE && !SCLK_OE;
  endproperty
  a_idle_float: assert property (p_idle_float) else $error("idle drive");

  property p_rest;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    busy && done_evt |=> SCLK_OUT == clock_polarity;
  endproperty
  a_rest: assert property (p_rest) else $error("clock not at rest");

  property p_order;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    load |=> MOSI_OUT == ($past(lsb) ? $past(thr_reg[0]) : $past(thr_reg[7]));
  endproperty
  a_order: assert property (p_order) else $error("wrong first bit");

  property p_start;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    load && is_master |=> busy ##1 (busy && half_reg == 4'h0);
  endproperty
  a_start: assert property (p_start) else $error("master no start");

  c_mdone: cover property (@(posedge CORE_CLK) busy && done_evt);
  c_sdone: cover property (@(posedge CORE_CLK) !busy && done_evt);
  c_mode:  cover property (@(posedge CORE_CLK) mode_chg);
  c_lsb:   cover property (@(posedge CORE_CLK) done_evt && lsb && clock_phase);

endmodule : smsp_port
`default_nettype wire

// file: dv/smsp_far_slave.sv
// Purpose: Behavioural SPI slave facing the port while it is master.
// Assumes: Mode inputs follow the port's control settings.
// Notes:   A released data line shows the inverse of its last bit.
`timescale 1ns/1ns
`default_nettype none
module smsp_far_slave
(
  input  wire logic       sclk,   // Serial clock line.
  input  wire logic       mosi,   // Data from the master.
  input  wire logic       sel_n,  // Select, active low.
  input  wire logic       clock_polarity,   // Clock idle level.
  input  wire logic       clock_phase,   // Clock phase.
  input  wire logic       lsb,    // Bit order, 1 is LSB first.
  input  wire logic       load,   // Loads a new reply byte.
  input  wire logic [7:0] tx,     // Reply byte.
  output logic            miso,   // Data to the master.
  output var logic [7:0]  sr      // Shift register, ends as received byte.
);
  logic drv = 1'b0; // Bit held on the line while selected.

  // ----------------------------------------------------------------------
  // Line and shifting
  // ----------------------------------------------------------------------
  // Released line is not left at its last value, so no stale bit passes.
  assign miso = sel_n ? ~drv : drv;

  // A new reply byte replaces the ring contents.
  always @(posedge load) sr = tx;

  // Phase 0 puts the first bit out as soon as select falls.
  always @(negedge sel_n) if (!clock_phase) drv = lsb ? sr[0] : sr[7];

  // Sample on one edge kind, change on the other; eight samples ring
  // the two bytes through each other.
  always @(sclk)
  begin
    if (!sel_n)
    begin
      if ((sclk != clock_polarity) ^ clock_phase)
        sr = lsb ? {mosi, sr[7:1]} : {sr[6:0], mosi};
      else
        drv = lsb ? sr[0] : sr[7];
    end
  end
endmodule : smsp_far_slave
`default_nettype wire

// file: dv/tb.sv
// Purpose: Self-checking bench of the SPI port in master and slave roles.
// Assumes: Far side is a behavioural slave; bench drives its select.
// Notes:   Inputs change on the falling edge of the system clock.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import smsp_pkg::*;
  logic       core_clk = 1'b0;            // System clock.
  logic       sys_rst = 1'b1;             // Reset.
  logic [7:0] addr = 8'h00;               // Register address.
  logic       wr_s = 1'b0;                // Write strobe.
  logic       rd_s = 1'b0;                // Read strobe.
  logic [7:0] wdata = 8'h00;              // Write data.
  logic [7:0] rdata;                      // Read data.
  logic       ie = 1'b0;                  // Interrupt enable.
  logic       ss_n = 1'b1;                // Port select pin.
  logic       irq, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic       mosi_last = 1'b0;           // Last driven MOSI bit.
  logic       p_sel_n = 1'b1;             // Far slave select.
  logic       clock_polarity = 1'b0;                // Clock polarity.
  logic       clock_phase = 1'b0;                // Clock phase.
  logic       lsb = 1'b0;                 // Bit order.
  logic       p_load = 1'b0;              // Far slave reply load.
  logic [7:0] p_tx = 8'h00;               // Far slave reply.
  logic       p_miso;                     // Far slave MISO.
  logic [7:0] p_sr;                       // Far slave received byte.
  logic       sclk_w, mosi_w, miso_w;     // Resolved line levels.
  logic       sclk_q = 1'b0;              // Previous clock drive.
  logic [7:0] cnt = 8'h00;                // Cycles since last toggle.
  logic [7:0] half_seen = 8'h00;          // Last measured half period.
  logic [7:0] v, a, x;                    // Read value and bytes.
  logic [2:0] sel;                        // Rate select.
  int         fail_count = 0;             // Mismatches.
  int         compares = 0;               // Comparisons.
  int         cycles = 0;                 // Timeout counter.
  int         seed = 32'h0000_10af;       // Random seed.

  // ----------------------------------------------------------------------
  // Clock, lines and instances
  // ----------------------------------------------------------------------
  always #2 core_clk = ~core_clk;
  // Undriven clock line rests at polarity; MOSI shows inverse of last bit.
  assign sclk_w = sclk_oe ? sclk_o : clock_polarity;
  assign mosi_w = mosi_oe ? mosi_o : ~mosi_last;
  assign miso_w = miso_oe ? miso_o : p_miso;

  smsp_port dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .SFR_ADDR(addr),
    .SFR_WR(wr_s), .SFR_RD(rd_s), .SFR_WDATA(wdata), .SFR_RDATA(rdata),
    .SPI_IE(ie), .SPI_IRQ(irq), .SS_N_IN(ss_n), .SCLK_IN(sclk_w),
    .SCLK_OUT(sclk_o), .SCLK_OE(sclk_oe), .MOSI_IN(mosi_w),
    .MOSI_OUT(mosi_o), .MOSI_OE(mosi_oe), .MISO_IN(miso_w),
    .MISO_OUT(miso_o), .MISO_OE(miso_oe));

  smsp_far_slave far (.sclk(sclk_w), .mosi(mosi_w), .sel_n(p_sel_n),
    .clock_polarity(clock_polarity), .clock_phase(clock_phase), .lsb(lsb), .load(p_load), .tx(p_tx),
    .miso(p_miso), .sr(p_sr));

  // Measures the serial clock half period and keeps the last MOSI bit.
  // It looks at the falling edge, where the driven levels have settled.
  always @(negedge core_clk)
  begin
    sclk_q <= sclk_o;
    if (mosi_oe) mosi_last <= mosi_o;
    if (sclk_o !== sclk_q)
    begin
      half_seen <= cnt;
      cnt <= 8'h01;
    end
    else
      cnt <= cnt + 8'h01;
  end

  // Cuts a hang short.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      close_out();
    end
  end

  // ----------------------------------------------------------------------
  // Tasks and functions
  // ----------------------------------------------------------------------
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge core_clk);
    addr = ad;
    wdata = d;
    wr_s = 1'b1;
    @(negedge core_clk);
    wr_s = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(negedge core_clk);
    addr = ad;
    rd_s = 1'b1;
    @(negedge core_clk);
    rd_s = 1'b0;
    @(negedge core_clk);
    d = rdata;
  endtask : rd

  // Polls the status register until the done flag shows.
  task automatic wait_done();
    for (int i = 0; i < 400; i++)
    begin
      rd(ADDR_STATUS, v);
      if (v[7] === 1'b1) break;
    end
    chk(v & 8'h80, 8'h80);
  endtask : wait_done

  // Half period in system cycles for each rate select value.
  function automatic logic [7:0] exp_half(input logic [2:0] s);
    logic [7:0] t [8] = '{8'h02, 8'h03, 8'h04, 8'h06,
                          8'h08, 8'h0C, 8'h18, 8'h30};
    return t[s];
  endfunction : exp_half

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    rd(ADDR_STATUS, v);
    chk(v, 8'h00);
    rd(ADDR_CTRL, v);
    chk(v, 8'h00);
    wr(8'h87, 8'hFF);
    rd(8'h87, v);
    chk(v, 8'h00);
    // Random master transfers; every rate value comes first.
    for (int i = 0; i < 12; i++)
    begin
      sel = (i < 8) ? 3'(i) : 3'($random(seed));
      {clock_polarity, clock_phase, lsb, ie} = 4'($random(seed));
      {a, x} = 16'($random(seed));
      p_tx = x;
      p_load = 1'b1;
      wr(ADDR_STATUS, {1'b1, 6'h00, sel[2]});
      p_load = 1'b0;
      wr(ADDR_CTRL, {2'b01, lsb, 1'b1, clock_polarity, clock_phase, sel[1:0]});
      chk({6'h00, sclk_oe, mosi_oe}, 8'h00);
      p_sel_n = 1'b0;
      wr(ADDR_DATA, a);
      rd(ADDR_STATUS, v);
      chk(v, {7'h00, sel[2]});
      chk({7'h00, sclk_oe}, 8'h01);
      wait_done();
      p_sel_n = 1'b1;
      chk(half_seen, exp_half(sel));
      chk(p_sr, a);
      chk({7'h00, sclk_o}, {7'h00, clock_polarity});
      chk({7'h00, irq}, {7'h00, ie});
      rd(ADDR_DATA, v);
      chk(v, x);
    end
    // Second byte pending while busy, then rings the first back.
    ie = 1'b1;
    lsb = 1'b0;
    {clock_polarity, clock_phase} = 2'b01;
    wr(ADDR_STATUS, 8'h81);
    wr(ADDR_CTRL, 8'h54);
    p_sel_n = 1'b0;
    wr(ADDR_DATA, 8'hA5);
    wr(ADDR_DATA, 8'h3C);
    rd(ADDR_STATUS, v);
    chk(v, 8'h41);
    wait_done();
    wr(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, v);
    chk(v, 8'h81);
    wr(ADDR_STATUS, 8'h81);
    chk({7'h00, irq}, 8'h00);
    wait_done();
    chk(p_sr, 8'h3C);
    rd(ADDR_DATA, v);
    chk(v, 8'hA5);
    p_sel_n = 1'b1;
    wr(ADDR_STATUS, 8'h80);
    // Select pulled low while master turns the port into a slave.
    wr(ADDR_CTRL, 8'h50);
    ss_n = 1'b0;
    // No data write is made while the select pin is held low.
    repeat (6) @(negedge core_clk);
    rd(ADDR_CTRL, v);
    chk(v, 8'h40);
    rd(ADDR_STATUS, v);
    chk(v, 8'h80);
    chk({7'h00, miso_oe}, 8'h01);
    wr(ADDR_CTRL, 8'h00);
    chk({5'h00, sclk_oe, mosi_oe, miso_oe}, 8'h00);
    // Ignore bit set: the select pin no longer changes the role.
    wr(ADDR_CTRL, 8'hD0);
    repeat (6) @(negedge core_clk);
    rd(ADDR_CTRL, v);
    chk(v, 8'hD0);
    chk({7'h00, sclk_oe}, 8'h01);
    ss_n = 1'b1;
    close_out();
  end
endmodule : tb
`default_nettype wire
